// ### rtl/stack_addr_pkg.sv
package stack_addr_pkg;
	// Register byte offsets (AXI4-Lite, one word each)
	localparam logic [7:0] ADDR_DEVICE_CONFIG  = 8'h00;
	localparam logic [7:0] ADDR_DEVICE_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_NODE_ID        = 8'h08;
	localparam logic [7:0] ADDR_BALANCE_CONFIG = 8'h0c;
	localparam logic [7:0] ADDR_BALANCE_ENABLE = 8'h10;
	localparam logic [7:0] ADDR_OVERSAMPLE     = 8'h14;
	localparam logic [7:0] ADDR_FAULT_MASK     = 8'h18;
	localparam logic [7:0] ADDR_GAIN_OFFSET    = 8'h1c;
	localparam logic [7:0] ADDR_CHANNEL_SEL    = 8'h20;
	localparam logic [7:0] ADDR_GPIO_CONFIG    = 8'h24;
	localparam logic [7:0] ADDR_STATUS         = 8'h28;
	// Field positions
	localparam int CFG_ADDR_SEL_BIT    = 0;
	localparam int CFG_AUTO_MON_BIT    = 1;
	localparam int CFG_UART_EN_BIT     = 2;
	localparam int CTRL_AUTO_ADDR_BIT  = 0;
	localparam int BALANCE_ON_FAULT_OPTION_BIT    = 0;
	localparam int OVS_ORDER_BIT       = 8;
	localparam int NODE_ID_W           = 5;
	// Reset values
	localparam logic [31:0] RST_DEVICE_CONFIG = 32'h0000_0005;
	localparam logic [4:0]  RST_NODE_ID       = 5'h00;
	localparam logic [31:0] RST_FAULT_MASK    = 32'h0000_0003;
	localparam logic [31:0] RST_OVERSAMPLE    = 32'h0000_0008;
	localparam logic [31:0] RST_CHANNEL_SEL   = 32'h0000_ffff;
	localparam logic [31:0] RST_GAIN_OFFSET   = 32'h0000_0000;
	localparam logic [31:0] RST_GPIO_CONFIG   = 32'h0000_0000;
	localparam logic [31:0] UART_BAUD         = 32'h0003_d090;
	// Fault bit positions: 0 ov, 1 uv (analog), rest digital/comm
	localparam int FAULT_W = 8;
	// Timing
	localparam int CLK_MHZ          = 125;
	localparam int BLOCK_NS         = 2000;
	localparam int BLOCK_CYC        = (BLOCK_NS * CLK_MHZ) / 1000;
	localparam int FIRST_SAMPLE_NS  = 60000;
	localparam int NEXT_SAMPLE_NS   = 12600;
	localparam int FIRST_SAMPLE_CYC = (FIRST_SAMPLE_NS * CLK_MHZ) / 1000;
	localparam int NEXT_SAMPLE_CYC  = (NEXT_SAMPLE_NS * CLK_MHZ) / 1000;
	localparam int NUM_CH           = 24;
	localparam int AUTO_MON_PERIOD  = 4096;
	typedef enum logic [2:0] {
		AA_IDLE = 3'b001,
		AA_WAIT = 3'b010,
		AA_DONE = 3'b100
	} aa_state_t;
endpackage : stack_addr_pkg

// ### rtl/stack_auto_addressing_ctrl.sv
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Select=1 and auto-address write enters addressing
// - High-side transmit off for one frame
// - Node id writable only while addressing waits
// - After frame, lock id, re-enable transmitter
// - Auto-monitor samples, stores, never transmits
// - Fault while balancing blocks writes 2 us
// - Order bit 0: all oversamples per channel
// - Order bit 1: sweep channels, repeat
// - Reset node id is 0x00
// - Digital faults unmasked, analog masked
// - Unmasked fault drives both fault outputs
// - Default 8 samples, 60/12.6 us timing
// - Default all sixteen cells, no aux
// - Default gain and offset zero
// - Default UART enabled, 250 Kbaud
// - Default GPIO inputs without pulls
// - Select=0 loads id from pins 4:0
// - Reset restores id from nonvolatile store
module stack_auto_addressing_ctrl
	import stack_addr_pkg::*;
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [7:0]           awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire logic [7:0]           araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	input  wire logic [NODE_ID_W-1:0] eeprom_node_id,
	input  wire logic [NODE_ID_W-1:0] gpio_addr_pins,
	input  wire logic                 frame_done,
	input  wire logic                 sample_ready,
	input  wire logic [FAULT_W-1:0]   fault_events,
	input  wire logic                 sample_req,
	output logic                      high_side_tx_en,
	output logic                      fault_n,
	output logic                      differential_fault_output,
	output logic                      sample_start,
	output logic [4:0]                sample_channel,
	output logic                      sample_tx_req
);
	logic [31:0]          device_config_register_q;
	logic [31:0]          balance_config_register_q;
	logic [31:0]          balance_enable_mask_q;
	logic [31:0]          oversample_register_q;
	logic [31:0]          fault_mask_q;
	logic [31:0]          gain_offset_q;
	logic [31:0]          channel_sel_q;
	logic [31:0]          gpio_config_q;
	logic [NODE_ID_W-1:0] node_id_field_q;
	logic [FAULT_W-1:0]   fault_q;
	aa_state_t            aa_q;
	logic                 aw_got_q, w_got_q;
	logic [7:0]           aw_addr_q;
	logic [31:0]          w_data_q;
	logic [3:0]           w_strb_q;
	logic                 load_q;
	logic [8:0]           block_cnt_q;
	logic                 do_write, wr_blocked, auto_addr_wr, fault_new, bal_active;
	logic [31:0]          wmask, wmerge;

	// Write channel: each side taken independently, commit when both held
	assign awready  = !aw_got_q && !bvalid;
	assign wready   = !w_got_q && !bvalid;
	assign do_write = aw_got_q && w_got_q && !bvalid;
	assign bresp    = 2'h0;
	assign rresp    = 2'h0;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{w_strb_q[i]}};
		end
		wmerge = w_data_q & wmask;
	end

	assign wr_blocked   = block_cnt_q != 9'h000;
	assign auto_addr_wr = do_write && !wr_blocked && aw_addr_q == ADDR_DEVICE_CONTROL
		&& w_strb_q[0] && w_data_q[CTRL_AUTO_ADDR_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid    <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_got_q  <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_got_q  <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (do_write) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid   <= 1'b1;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Config registers; dropped writes still answer OKAY, host must check
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			device_config_register_q  <= RST_DEVICE_CONFIG;
			balance_config_register_q <= 32'h0000_0000;
			balance_enable_mask_q     <= 32'h0000_0000;
			oversample_register_q     <= RST_OVERSAMPLE;
			fault_mask_q              <= RST_FAULT_MASK;
			gain_offset_q             <= RST_GAIN_OFFSET;
			channel_sel_q             <= RST_CHANNEL_SEL;
			gpio_config_q             <= RST_GPIO_CONFIG;
		end else if (do_write && !wr_blocked) begin
			case (aw_addr_q)
				ADDR_DEVICE_CONFIG:  device_config_register_q  <= (device_config_register_q & ~wmask) | wmerge;
				ADDR_BALANCE_CONFIG: balance_config_register_q <= (balance_config_register_q & ~wmask) | wmerge;
				ADDR_BALANCE_ENABLE: balance_enable_mask_q     <= (balance_enable_mask_q & ~wmask) | wmerge;
				ADDR_OVERSAMPLE:     oversample_register_q     <= (oversample_register_q & ~wmask) | wmerge;
				ADDR_FAULT_MASK:     fault_mask_q              <= (fault_mask_q & ~wmask) | wmerge;
				ADDR_GAIN_OFFSET:    gain_offset_q             <= (gain_offset_q & ~wmask) | wmerge;
				ADDR_CHANNEL_SEL:    channel_sel_q             <= (channel_sel_q & ~wmask) | wmerge;
				ADDR_GPIO_CONFIG:    gpio_config_q             <= (gpio_config_q & ~wmask) | wmerge;
				default: ;
			endcase
		end
	end

	// Auto-addressing state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aa_q <= AA_IDLE;
		end else begin
			case (aa_q)
				AA_IDLE: if (auto_addr_wr && device_config_register_q[CFG_ADDR_SEL_BIT]) aa_q <= AA_WAIT;
				AA_WAIT: if (frame_done) aa_q <= AA_DONE;
				AA_DONE: aa_q <= AA_IDLE;
				default: aa_q <= AA_IDLE;
			endcase
		end
	end

	assign high_side_tx_en = aa_q != AA_WAIT;

	// Node id: strap/eeprom load one cycle after reset release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			node_id_field_q <= RST_NODE_ID;
			load_q          <= 1'b1;
		end else begin
			load_q <= 1'b0;
			if (load_q) begin
				node_id_field_q <= device_config_register_q[CFG_ADDR_SEL_BIT]
					? eeprom_node_id : gpio_addr_pins;
			end else if (auto_addr_wr && !device_config_register_q[CFG_ADDR_SEL_BIT]) begin
				node_id_field_q <= gpio_addr_pins;
			end else if (do_write && !wr_blocked && aa_q == AA_WAIT && aw_addr_q == ADDR_NODE_ID
				&& w_strb_q[0]) begin
				node_id_field_q <= w_data_q[NODE_ID_W-1:0];
			end
		end
	end

	// Faults: sticky, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_q <= '0;
		end else if (do_write && !wr_blocked && aw_addr_q == ADDR_STATUS && w_strb_q[1]) begin
			fault_q <= (fault_q & ~w_data_q[15:8]) | fault_events;
		end else begin
			fault_q <= fault_q | fault_events;
		end
	end

	assign fault_new  = |(fault_events & ~fault_mask_q[FAULT_W-1:0]);
	assign bal_active = balance_config_register_q[BALANCE_ON_FAULT_OPTION_BIT] && balance_enable_mask_q != 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			block_cnt_q <= 9'h000;
		end else if (fault_new && bal_active) begin
			block_cnt_q <= 9'(BLOCK_CYC);
		end else if (wr_blocked) begin
			block_cnt_q <= block_cnt_q - 9'h001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_n                   <= 1'b1;
			differential_fault_output <= 1'b0;
		end else begin
			fault_n                   <= ~|(fault_q & ~fault_mask_q[FAULT_W-1:0]);
			differential_fault_output <= |(fault_q & ~fault_mask_q[FAULT_W-1:0]);
		end
	end

	// Conversion sequencer
	logic [4:0]  ch_q;
	logic [7:0]  ovs_q;
	logic        busy_q, first_q;
	logic [12:0] tmr_q;
	logic [12:0] mon_q;
	logic        trig, host_trig, ovs_order;
	logic [4:0]  nxt_ch;
	logic        last_ch;
	assign ovs_order = oversample_register_q[OVS_ORDER_BIT];
	assign host_trig = sample_req && !device_config_register_q[CFG_AUTO_MON_BIT];
	assign trig      = !busy_q && (host_trig || (device_config_register_q[CFG_AUTO_MON_BIT]
		&& mon_q == 13'h0000));

	always_comb begin
		nxt_ch  = ch_q;
		last_ch = 1'b1;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (i > int'(ch_q) && channel_sel_q[i]) begin
				nxt_ch  = 5'(i);
				last_ch = 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mon_q <= 13'(AUTO_MON_PERIOD);
		end else if (!device_config_register_q[CFG_AUTO_MON_BIT] || mon_q == 13'h0000) begin
			mon_q <= 13'(AUTO_MON_PERIOD);
		end else begin
			mon_q <= mon_q - 13'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_q         <= 1'b0;
			first_q        <= 1'b0;
			ch_q           <= 5'h00;
			ovs_q          <= 8'h00;
			tmr_q          <= 13'h0000;
			sample_start   <= 1'b0;
			sample_channel <= 5'h00;
			sample_tx_req  <= 1'b0;
		end else begin
			sample_start  <= 1'b0;
			sample_tx_req <= 1'b0;
			if (trig) begin
				busy_q  <= 1'b1;
				first_q <= host_trig;
				ch_q    <= 5'h00;
				ovs_q   <= 8'h01;
				tmr_q   <= 13'(FIRST_SAMPLE_CYC);
			end else if (busy_q) begin
				if (tmr_q != 13'h0000) begin
					tmr_q <= tmr_q - 13'h0001;
				end else begin
					sample_start   <= 1'b1;
					sample_channel <= ch_q;
					tmr_q          <= 13'(NEXT_SAMPLE_CYC);
					if (!ovs_order) begin
						if (ovs_q < oversample_register_q[7:0]) begin
							ovs_q <= ovs_q + 8'h01;
						end else if (!last_ch) begin
							ch_q  <= nxt_ch;
							ovs_q <= 8'h01;
						end else begin
							busy_q        <= 1'b0;
							sample_tx_req <= first_q;
						end
					end else begin
						if (!last_ch) begin
							ch_q <= nxt_ch;
						end else if (ovs_q < oversample_register_q[7:0]) begin
							ch_q  <= 5'h00;
							ovs_q <= ovs_q + 8'h01;
						end else begin
							busy_q        <= 1'b0;
							sample_tx_req <= first_q;
						end
					end
				end
			end
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
		end else if (rvalid) begin
			if (rready) rvalid <= 1'b0;
		end else if (arvalid) begin
			rvalid <= 1'b1;
			case (araddr)
				ADDR_DEVICE_CONFIG:  rdata <= device_config_register_q;
				ADDR_DEVICE_CONTROL: rdata <= {31'h0, aa_q == AA_WAIT};
				ADDR_NODE_ID:        rdata <= {27'h0, node_id_field_q};
				ADDR_BALANCE_CONFIG: rdata <= balance_config_register_q;
				ADDR_BALANCE_ENABLE: rdata <= balance_enable_mask_q;
				ADDR_OVERSAMPLE:     rdata <= oversample_register_q;
				ADDR_FAULT_MASK:     rdata <= fault_mask_q;
				ADDR_GAIN_OFFSET:    rdata <= gain_offset_q;
				ADDR_CHANNEL_SEL:    rdata <= channel_sel_q;
				ADDR_GPIO_CONFIG:    rdata <= gpio_config_q;
				ADDR_STATUS:         rdata <= {15'h0, busy_q, fault_q, 7'h0, wr_blocked};
				default:             rdata <= 32'h0000_0000;
			endcase
		end
	end
	assign arready = !rvalid;

	// Checks
	a_aa_enter: assert property (@(posedge aclk) disable iff (!aresetn)
		aa_q == AA_IDLE && auto_addr_wr && device_config_register_q[CFG_ADDR_SEL_BIT] |=> aa_q == AA_WAIT)
		else $error("auto address not entered");
	a_tx_off_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		aa_q == AA_WAIT && !frame_done |=> !high_side_tx_en)
		else $error("transmitter not held off");
	a_id_locked: assert property (@(posedge aclk) disable iff (!aresetn)
		aa_q != AA_WAIT && !load_q && !auto_addr_wr |=> $stable(node_id_field_q))
		else $error("node id changed while locked");
	sequence s_frame_end;
		aa_q == AA_WAIT && frame_done;
	endsequence
	a_tx_restored: assert property (@(posedge aclk) disable iff (!aresetn)
		s_frame_end |=> high_side_tx_en ##1 aa_q == AA_IDLE)
		else $error("transmitter not restored");
	a_no_auto_tx: assert property (@(posedge aclk) disable iff (!aresetn)
		busy_q && !first_q |=> !sample_tx_req)
		else $error("auto-monitor transmitted");
	a_block_write: assert property (@(posedge aclk) disable iff (!aresetn)
		fault_new && bal_active |=> wr_blocked [*8])
		else $error("writes not blocked after fault");
	a_fault_pins: assert property (@(posedge aclk) disable iff (!aresetn)
		|(fault_q & ~fault_mask_q[FAULT_W-1:0]) |=> !fault_n && differential_fault_output)
		else $error("fault outputs not driven");
	a_ovs_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		busy_q && !trig && !ovs_order && ovs_q < oversample_register_q[7:0] |=> ch_q == $past(ch_q))
		else $error("channel advanced early");
endmodule : stack_auto_addressing_ctrl

// ### tb/stack_link_model.sv
`timescale 1ns/1ps
module stack_link_model (
	input  wire logic       aclk,
	input  wire logic       send,
	input  wire logic [7:0] gap,
	output logic            frame_done
);
	// One frame end per request; the gap makes the link prompt or slow
	initial frame_done = 1'b0;
	always @(posedge aclk) begin
		if (send) begin
			repeat (gap) @(posedge aclk);
			frame_done <= 1'b1;
			@(posedge aclk);
			frame_done <= 1'b0;
		end
	end
endmodule : stack_link_model

// ### tb/stack_auto_addressing_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module stack_auto_addressing_ctrl_bench;
	import stack_addr_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr, gap;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [4:0]  eeprom_node_id, gpio_addr_pins, sample_channel, nid, gp;
	logic [7:0]  fault_events;
	logic        frame_done, sample_req, high_side_tx_en, fault_n, diff_fault, sample_start, sample_tx_req, send, ch_on;
	logic [15:0] g;
	logic [31:0] q[$];
	logic [4:0]  chq[$];
	int          error_cnt, compares, cyc, tx_cnt, st_cnt, n, t0, s0;

	stack_auto_addressing_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .eeprom_node_id(eeprom_node_id),
		.gpio_addr_pins(gpio_addr_pins), .frame_done(frame_done), .sample_ready(1'b0),
		.fault_events(fault_events), .sample_req(sample_req), .high_side_tx_en(high_side_tx_en),
		.fault_n(fault_n), .differential_fault_output(diff_fault), .sample_start(sample_start),
		.sample_channel(sample_channel), .sample_tx_req(sample_tx_req));
	stack_link_model i_link (.aclk(aclk), .send(send), .gap(gap), .frame_done(frame_done));

	always #4 aclk = ~aclk;

	task final_report;
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	// Read results and conversion order are judged against the oldest note
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 100000) begin
			error_cnt++;
			final_report();
		end
		if (rvalid && rready) begin
			if (q.size() == 0) `CHK(1'b0, 1'b1)
			else `CHK(rdata, q.pop_front())
		end
		if (sample_start) begin
			st_cnt++;
			if (ch_on) begin
				if (chq.size() == 0) `CHK(1'b0, 1'b1)
				else `CHK(sample_channel, chq.pop_front())
			end
		end
		if (sample_tx_req === 1'b1) tx_cnt++;
	end

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				done = 1'b1;
				bready <= 1'b0;
			end
		end
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		logic done;
		done = 1'b0;
		q.push_back(e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				done = 1'b1;
				rready <= 1'b0;
			end
		end
	endtask : rd

	task settle(input int c);
		repeat (c) @(posedge aclk);
		#1;
	endtask : settle

	task pulse_fault(input logic [7:0] v);
		@(posedge aclk);
		fault_events <= v;
		@(posedge aclk);
		fault_events <= 8'h00;
	endtask : pulse_fault

	task convert(input logic order);
		wr(ADDR_OVERSAMPLE, {23'h0, order, 8'h02});
		ch_on = 1'b1;
		t0 = tx_cnt;
		@(posedge aclk);
		sample_req <= 1'b1;
		@(posedge aclk);
		sample_req <= 1'b0;
		for (n = 0; n < 20000 && chq.size() > 0; n++) @(posedge aclk);
		settle(2500);
		`CHK(chq.size(), 0)
		`CHK(tx_cnt, t0 + 1)
		ch_on = 1'b0;
	endtask : convert

	initial begin
		aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
		rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf; eeprom_node_id = 5'h00;
		gpio_addr_pins = 5'h00; fault_events = 8'h00; sample_req = 1'b0; send = 1'b0; gap = 8'h28; ch_on = 1'b0;
		error_cnt = 0; compares = 0; cyc = 0; tx_cnt = 0; st_cnt = 0;
		n = $urandom(26247);
		nid = 5'($urandom_range(1, 31));
		gp = 5'($urandom_range(1, 31));
		g = 16'($urandom_range(1, 65535));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_DEVICE_CONFIG, RST_DEVICE_CONFIG);
		rd(ADDR_NODE_ID, 32'h0);
		rd(ADDR_FAULT_MASK, RST_FAULT_MASK);
		rd(ADDR_OVERSAMPLE, RST_OVERSAMPLE);
		rd(ADDR_CHANNEL_SEL, RST_CHANNEL_SEL);
		rd(ADDR_GAIN_OFFSET, RST_GAIN_OFFSET);
		rd(ADDR_GPIO_CONFIG, RST_GPIO_CONFIG);
		rd(8'h3c, 32'h0);
		wr(ADDR_NODE_ID, {27'h0, nid});
		rd(ADDR_NODE_ID, 32'h0);
		wr(ADDR_DEVICE_CONTROL, 32'h1);
		settle(1);
		`CHK(high_side_tx_en, 1'b0)
		rd(ADDR_DEVICE_CONTROL, 32'h1);
		wr(ADDR_NODE_ID, {27'h0, nid});
		rd(ADDR_NODE_ID, {27'h0, nid});
		@(posedge aclk);
		send <= 1'b1;
		@(posedge aclk);
		send <= 1'b0;
		for (n = 0; n < 200 && high_side_tx_en !== 1'b1; n++) @(posedge aclk);
		`CHK(high_side_tx_en, 1'b1)
		rd(ADDR_DEVICE_CONTROL, 32'h0);
		wr(ADDR_NODE_ID, {27'h0, ~nid});
		rd(ADDR_NODE_ID, {27'h0, nid});
		wr(ADDR_DEVICE_CONFIG, 32'h4);
		gpio_addr_pins <= gp;
		wr(ADDR_DEVICE_CONTROL, 32'h1);
		rd(ADDR_NODE_ID, {27'h0, gp});
		`CHK(high_side_tx_en, 1'b1)
		wr(ADDR_DEVICE_CONFIG, RST_DEVICE_CONFIG);
		pulse_fault(8'h03);
		settle(3);
		`CHK({fault_n, diff_fault}, 2'b10)
		pulse_fault(8'h04);
		settle(3);
		`CHK({fault_n, diff_fault}, 2'b01)
		wr(ADDR_STATUS, 32'h0000ff00);
		settle(3);
		`CHK(fault_n, 1'b1)
		// Block window only opens with the option set and a balance enable live
		wr(ADDR_BALANCE_CONFIG, 32'h1);
		wr(ADDR_BALANCE_ENABLE, 32'h1);
		pulse_fault(8'h04);
		wr(ADDR_GAIN_OFFSET, {16'h0, g});
		rd(ADDR_GAIN_OFFSET, 32'h0);
		settle(260);
		wr(ADDR_GAIN_OFFSET, {16'h0, g});
		rd(ADDR_GAIN_OFFSET, {16'h0, g});
		wr(ADDR_BALANCE_ENABLE, 32'h0);
		pulse_fault(8'h04);
		wr(ADDR_GAIN_OFFSET, 32'h0);
		rd(ADDR_GAIN_OFFSET, 32'h0);
		wr(ADDR_STATUS, 32'h0000ff00);
		wr(ADDR_CHANNEL_SEL, 32'h7);
		chq = '{5'd0, 5'd0, 5'd1, 5'd1, 5'd2, 5'd2};
		convert(1'b0);
		chq = '{5'd0, 5'd1, 5'd2, 5'd0, 5'd1, 5'd2};
		convert(1'b1);
		t0 = tx_cnt;
		s0 = st_cnt;
		wr(ADDR_DEVICE_CONFIG, 32'h7);
		// A host request while monitoring must not produce a transmit
		@(posedge aclk);
		sample_req <= 1'b1;
		@(posedge aclk);
		sample_req <= 1'b0;
		// Period plus one full three-channel pass, so samples must appear
		settle(20000);
		`CHK(tx_cnt, t0)
		`CHK(st_cnt > s0, 1'b1)
		wr(ADDR_DEVICE_CONFIG, RST_DEVICE_CONFIG);
		@(posedge aclk);
		aresetn <= 1'b0;
		eeprom_node_id <= nid;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_NODE_ID, {27'h0, nid});
		settle(4);
		final_report();
	end
endmodule : stack_auto_addressing_ctrl_bench
